// file: common/dpio_pkg.sv
// Constants, field layouts and carrier types for the dual I/O port block
package dpio_pkg;

  // ****************************************
  // Special-function register addresses
  // ****************************************
  localparam logic [7:0] ADDR_PORT1      = 8'h90;
  localparam logic [7:0] ADDR_PORT1_DIRL = 8'hae;
  localparam logic [7:0] ADDR_PORT1_DIRH = 8'haf;
  localparam logic [7:0] ADDR_PORT3      = 8'hb0;
  localparam logic [7:0] ADDR_PORT3_DIRL = 8'hb3;
  localparam logic [7:0] ADDR_PORT3_DIRH = 8'hb4;
  localparam logic [7:0] ADDR_ALT_SEL    = 8'hf2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_LATCH = 8'hff;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [7:0] RST_ALT   = 8'h00;
  localparam logic [7:0] RD_UNMAP  = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_W       = 2;
  localparam int TMR_CNT0_BIT = 1;
  localparam int TMR_CNT1_BIT = 2;
  localparam int ALT_SEL_LSB  = 0;
  localparam int ALT_SEL_W    = 2;

  // Pin indices in the joined 16-bit view {port3, port1}
  localparam int PIN_STRAP    = 0;
  localparam int PIN_DOUT     = 2;
  localparam int PIN_IRQ2     = 4;
  localparam int PIN_IRQ3     = 5;
  localparam int PIN_IRQ4     = 6;
  localparam int PIN_IRQ5     = 7;
  localparam int PIN_RXD      = 8;
  localparam int PIN_TXD      = 9;
  localparam int PIN_IRQ0     = 10;
  localparam int PIN_IRQ1     = 11;
  localparam int PIN_TMR0_CLK = 12;
  localparam int PIN_TMR1_CLK = 13;
  localparam int PIN_CLK_OUT  = 14;

  typedef enum logic [1:0] {
    MODE_QUASI = 2'h0,
    MODE_INPUT = 2'h1,
    MODE_PUSH  = 2'h2,
    MODE_OPEN  = 2'h3
  } dpio_mode_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpio_sfr_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } dpio_pad_t;

endpackage

// file: logic/dpio_port.sv
// Two 8-bit configurable I/O ports with alternate-function routing
`timescale 1ns/100ps
// Function
// - Eight bits each drivable low, high, readable
// - Port read reflects alternate function state
// - Pull-up on in default quasi mode
// - Pull-up off for push, open-drain, input
// - Quasi mode weak high, strong low, readable
// - Pin 1.4 rising interrupt or slave select
// - Pin 1.5 falling edge interrupt three
// - Pin 1.6 rising edge interrupt four
// - Pin 1.7 falling interrupt or serial clock
// - Pins 3.0/3.1 carry USART receive/transmit
// - Pins 3.2/3.3 level or falling interrupts
// - Pins 3.4/3.5 clock timers when selected
// - Pin 3.6 function chosen by selector register
module dpio_port import dpio_pkg::*; (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // Special-function register access
  input  wire dpio_sfr_req_t sfr_req,
  output logic [7:0]         sfr_rdata_q,
  // Pads
  input  wire logic [7:0]    port1_pin_in,
  input  wire logic [7:0]    port3_pin_in,
  output dpio_pad_t          port1_pad_q,
  output dpio_pad_t          port3_pad_q,
  // Peripheral side
  input  wire logic          spi_active,
  input  wire logic          i2c_active,
  input  wire logic          spi_dout,
  input  wire logic          serial_clk_drive,
  input  wire logic          serial_clk_out,
  input  wire logic          usart_transmit_line,
  input  wire logic [2:0]    clk_pin_src,
  input  wire logic [7:0]    timer_mode_reg,
  input  wire logic [1:0]    ext_irq_level_mode,
  output logic [5:0]         ext_irq_q,
  output logic               spi_slave_sel_n_q,
  output logic               serial_clk_in_q,
  output logic               usart_receive_line_q,
  output logic               timer0_ext_clock_q,
  output logic               timer1_ext_clock_q,
  output logic               serial_program_strap_q
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] latch_q;
  logic [15:0] dir_low_q;
  logic [15:0] dir_high_q;
  logic [7:0]  alt_sel_q;
  logic [15:0] pin_q;
  logic [15:0] pin_prev_q;
  logic [15:0] val_d;
  dpio_mode_t  mode [16];
  logic [15:0] alt_val;
  logic [15:0] oe_d;
  logic [15:0] pu_d;
  logic [1:0]  clk_sel;

  assign clk_sel = alt_sel_q[ALT_SEL_LSB +: ALT_SEL_W];

  always_ff @(posedge clk) begin
    if (srst) begin
      latch_q    <= {RST_LATCH, RST_LATCH};
      dir_low_q  <= {RST_DIR, RST_DIR};
      dir_high_q <= {RST_DIR, RST_DIR};
      alt_sel_q  <= RST_ALT;
    end else if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        ADDR_PORT1:      latch_q[7:0]     <= sfr_req.wdata;
        ADDR_PORT3:      latch_q[15:8]    <= sfr_req.wdata;
        ADDR_PORT1_DIRL: dir_low_q[7:0]   <= sfr_req.wdata;
        ADDR_PORT1_DIRH: dir_high_q[7:0]  <= sfr_req.wdata;
        ADDR_PORT3_DIRL: dir_low_q[15:8]  <= sfr_req.wdata;
        ADDR_PORT3_DIRH: dir_high_q[15:8] <= sfr_req.wdata;
        ADDR_ALT_SEL:    alt_sel_q        <= sfr_req.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Port reads return the pin, so an alternate function shows through
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata_q <= RD_UNMAP;
    end else if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        ADDR_PORT1:      sfr_rdata_q <= pin_q[7:0];
        ADDR_PORT3:      sfr_rdata_q <= pin_q[15:8];
        ADDR_PORT1_DIRL: sfr_rdata_q <= dir_low_q[7:0];
        ADDR_PORT1_DIRH: sfr_rdata_q <= dir_high_q[7:0];
        ADDR_PORT3_DIRL: sfr_rdata_q <= dir_low_q[15:8];
        ADDR_PORT3_DIRH: sfr_rdata_q <= dir_high_q[15:8];
        ADDR_ALT_SEL:    sfr_rdata_q <= alt_sel_q;
        default:         sfr_rdata_q <= RD_UNMAP;
      endcase
    end
  end

  // ****************************************
  // Alternate outputs
  // ****************************************
  // Undriven alternates sit at one so the latch alone decides
  always_comb begin
    alt_val              = 16'hffff;
    alt_val[PIN_DOUT]    = spi_active ? spi_dout : 1'b1;
    alt_val[PIN_IRQ5]    = ((spi_active || i2c_active) && serial_clk_drive) ? serial_clk_out : 1'b1;
    alt_val[PIN_TXD]     = usart_transmit_line;
    alt_val[PIN_CLK_OUT] = (clk_sel == 2'h0) ? 1'b1 : clk_pin_src[clk_sel - 2'h1];
  end

  // ****************************************
  // Per-pin drive
  // ****************************************
  for (genvar b = 0; b < 16; b++) begin : g_pin
    localparam int F = (b % 4) * MODE_W;
    logic oe_b;
    logic pu_b;
    assign mode[b]  = dpio_mode_t'((b % 8) < 4 ? dir_low_q[(b / 8) * 8 + F +: MODE_W]
                                               : dir_high_q[(b / 8) * 8 + F +: MODE_W]);
    assign val_d[b] = latch_q[b] & alt_val[b];
    always_comb begin
      unique case (mode[b])
        MODE_QUASI: begin
          oe_b = ~val_d[b];
          pu_b = 1'b1;
        end
        MODE_INPUT: begin
          oe_b = 1'b0;
          pu_b = 1'b0;
        end
        MODE_PUSH: begin
          oe_b = 1'b1;
          pu_b = 1'b0;
        end
        MODE_OPEN: begin
          oe_b = ~val_d[b];
          pu_b = 1'b0;
        end
      endcase
    end
    // One process per bit, so the shared vectors take plain assigns
    assign oe_d[b] = oe_b;
    assign pu_d[b] = pu_b;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port1_pad_q <= '{out: RST_LATCH, oe: 8'h00, pu: 8'hff};
      port3_pad_q <= '{out: RST_LATCH, oe: 8'h00, pu: 8'hff};
    end else begin
      port1_pad_q <= '{out: val_d[7:0], oe: oe_d[7:0], pu: pu_d[7:0]};
      port3_pad_q <= '{out: val_d[15:8], oe: oe_d[15:8], pu: pu_d[15:8]};
    end
  end

  // ****************************************
  // Input sampling and alternate inputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_q      <= 16'hffff;
      pin_prev_q <= 16'hffff;
    end else begin
      pin_q      <= {port3_pin_in, port1_pin_in};
      pin_prev_q <= pin_q;
    end
  end

  // Strap sampled through every reset cycle; last one before release sticks
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_program_strap_q <= ~port1_pin_in[PIN_STRAP];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_irq_q <= 6'h00;
    end else begin
      ext_irq_q[0] <= ext_irq_level_mode[0] ? ~pin_q[PIN_IRQ0]
                                            : pin_prev_q[PIN_IRQ0] & ~pin_q[PIN_IRQ0];
      ext_irq_q[1] <= ext_irq_level_mode[1] ? ~pin_q[PIN_IRQ1]
                                            : pin_prev_q[PIN_IRQ1] & ~pin_q[PIN_IRQ1];
      ext_irq_q[2] <= ~spi_active & ~pin_prev_q[PIN_IRQ2] & pin_q[PIN_IRQ2];
      ext_irq_q[3] <= pin_prev_q[PIN_IRQ3] & ~pin_q[PIN_IRQ3];
      ext_irq_q[4] <= ~pin_prev_q[PIN_IRQ4] & pin_q[PIN_IRQ4];
      ext_irq_q[5] <= ~(spi_active | i2c_active) & pin_prev_q[PIN_IRQ5] & ~pin_q[PIN_IRQ5];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      spi_slave_sel_n_q    <= 1'b1;
      serial_clk_in_q      <= 1'b1;
      usart_receive_line_q <= 1'b1;
      timer0_ext_clock_q   <= 1'b0;
      timer1_ext_clock_q   <= 1'b0;
    end else begin
      spi_slave_sel_n_q    <= spi_active ? pin_q[PIN_IRQ2] : 1'b1;
      serial_clk_in_q      <= (spi_active | i2c_active) ? pin_q[PIN_IRQ5] : 1'b1;
      usart_receive_line_q <= pin_q[PIN_RXD];
      timer0_ext_clock_q   <= timer_mode_reg[TMR_CNT0_BIT] & pin_q[PIN_TMR0_CLK];
      timer1_ext_clock_q   <= timer_mode_reg[TMR_CNT1_BIT] & pin_q[PIN_TMR1_CLK];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_irq3_fall;
    $fell(pin_q[PIN_IRQ3]);
  endsequence
  sequence s_irq4_rise;
    $rose(pin_q[PIN_IRQ4]);
  endsequence

  a_quasi_pullup: assert property (mode[3] == MODE_QUASI |=> port1_pad_q.pu[3])
    else $error("quasi pin lacks pull-up");
  a_pullup_off: assert property (mode[1] != MODE_QUASI |=> !port1_pad_q.pu[1])
    else $error("pull-up on outside quasi mode");
  a_quasi_weak: assert property (mode[0] == MODE_QUASI && latch_q[0] |=> !port1_pad_q.oe[0])
    else $error("quasi high driven strongly");
  a_irq3_falling: assert property (s_irq3_fall |=> ext_irq_q[3] ##1 !ext_irq_q[3])
    else $error("interrupt three not a single pulse");
  a_irq4_rising: assert property (s_irq4_rise |=> ext_irq_q[4])
    else $error("interrupt four missed");
  a_irq2_spi_off: assert property (spi_active |=> !ext_irq_q[2])
    else $error("interrupt two during slave select");
  a_irq0_level: assert property (ext_irq_level_mode[0] && !pin_q[PIN_IRQ0] |=> ext_irq_q[0])
    else $error("level interrupt zero missed");
  a_txd_route: assert property (latch_q[PIN_TXD] |=>
                                port3_pad_q.out[1] == $past(usart_transmit_line))
    else $error("transmit not on pin");
  a_timer0_gate: assert property (!timer_mode_reg[TMR_CNT0_BIT] |=> !timer0_ext_clock_q)
    else $error("timer clock passed while deselected");
  a_port_read: assert property (sfr_req.rd && sfr_req.addr == ADDR_PORT1 |=>
                                sfr_rdata_q == $past(pin_q[7:0]))
    else $error("port read not pin state");

endmodule

// file: verification/dpio_board.sv
// Board-side model of one port: external drivers and pin resolution
`timescale 1ns/100ps
module dpio_board import dpio_pkg::*; (
  // Clock
  input  wire logic       clk,
  // Device pads
  input  wire dpio_pad_t  pad,
  // Board drivers
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // Resolved pin levels
  output logic [7:0]      pin
);
  // ****
  // Float pattern
  // ****
  // Undriven lines without pull-up toggle so a stale level never passes
  logic float_q = 1'b0;
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) begin
        pin[i] = pad.out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pad.pu[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = float_q;
      end
    end
  end
endmodule

// file: verification/dpio_port_bench.sv
// Self-checking bench for the dual I/O port block
`timescale 1ns/100ps
module dpio_port_bench import dpio_pkg::*; ;
  // ****
  // Stimulus and observation
  // ****
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  dpio_sfr_req_t req = '0;
  dpio_pad_t     pad1, pad3;
  logic [7:0]    rdata, p1_in, p3_in, tmr_mode = '0;
  logic [7:0]    e1_v = 8'hfe, e1_e = 8'h01, e3_v = 8'hff, e3_e = 8'h00;
  logic          spi_act = 1'b0, sdo = 1'b1, sck_out = 1'b1, txd = 1'b1;
  logic          i2c_act = 1'b0, sck_drv = 1'b0;
  logic [2:0]    cps = '0;
  logic [1:0]    lvl = '0;
  logic [5:0]    irq;
  logic          ss_n, sck_in, rxd, t0c, t1c, strap;
  int            err_count = 0;
  int            checks_done = 0;
  always #50 clk = ~clk;
  dpio_board u_dpio_board_p1 (.clk(clk), .pad(pad1), .ext_val(e1_v), .ext_en(e1_e), .pin(p1_in));
  dpio_board u_dpio_board_p3 (.clk(clk), .pad(pad3), .ext_val(e3_v), .ext_en(e3_e), .pin(p3_in));
  dpio_port u_dpio_port (.clk(clk), .srst(srst), .sfr_req(req), .sfr_rdata_q(rdata),
    .port1_pin_in(p1_in), .port3_pin_in(p3_in), .port1_pad_q(pad1), .port3_pad_q(pad3),
    .spi_active(spi_act), .i2c_active(i2c_act), .spi_dout(sdo), .serial_clk_drive(sck_drv),
    .serial_clk_out(sck_out), .usart_transmit_line(txd), .clk_pin_src(cps), .timer_mode_reg(tmr_mode),
    .ext_irq_level_mode(lvl), .ext_irq_q(irq), .spi_slave_sel_n_q(ss_n), .serial_clk_in_q(sck_in),
    .usart_receive_line_q(rxd), .timer0_ext_clock_q(t0c), .timer1_ext_clock_q(t1c),
    .serial_program_strap_q(strap));
  // ****
  // Shared tasks
  // ****
  task chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held one cycle; three more edges let pads settle
  task sfr(logic w, logic [7:0] a, logic [7:0] d);
    req <= '{w, ~w, a, d};
    @(posedge clk);
    req <= '0;
    cyc(3);
  endtask
  task drv(int p, logic v);
    if (p < 8) begin
      e1_e[p] <= 1'b1;
      e1_v[p] <= v;
    end else begin
      e3_e[p-8] <= 1'b1;
      e3_v[p-8] <= v;
    end
  endtask
  task irq_pin(int p, logic v, int i, int exp);
    int hits;
    hits = 0;
    drv(p, v);
    repeat (6) begin
      @(posedge clk);
      if (irq[i] === 1'b1) hits++;
    end
    chk("irq hits", hits[7:0], exp[7:0]);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset;
    cyc(20);
    srst <= 1'b0;
    @(posedge clk);
    e1_e <= 8'h00;
    cyc(2);
    chk("strap", {7'h0, strap}, 8'h01);
    chk("p1 pad", pad1.pu & ~pad1.oe & pad1.out, 8'hff);
    chk("p3 pad", pad3.pu & ~pad3.oe & pad3.out, 8'hff);
    $display("reset test done");
  endtask
  task t_regs;
    logic [7:0] adr [5] = '{ADDR_PORT1_DIRL, ADDR_PORT1_DIRH, ADDR_PORT3_DIRL, ADDR_PORT3_DIRH, ADDR_ALT_SEL};
    foreach (adr[k]) begin
      sfr(1'b0, adr[k], 8'h00);
      chk("reset reg", rdata, RST_DIR);
    end
    sfr(1'b0, 8'h91, 8'h00);
    chk("unmapped", rdata, RD_UNMAP);
    $display("register test done");
  endtask
  task t_modes;
    sfr(1'b1, ADDR_PORT1_DIRL, 8'he4);
    chk("pu modes", {4'h0, pad1.pu[3:0]}, 8'h01);
    chk("push oe", {7'h0, pad1.oe[2]}, 8'h01);
    sfr(1'b1, ADDR_PORT1, 8'hf0);
    chk("low oe", {4'h0, pad1.oe[3:0]}, 8'h0d);
    chk("low out", {4'h0, pad1.out[3:0]}, 8'h00);
    sfr(1'b0, ADDR_PORT1_DIRL, 8'h00);
    chk("dir low", rdata, 8'he4);
    sfr(1'b1, ADDR_PORT1, 8'hff);
    sfr(1'b1, ADDR_PORT1_DIRL, 8'h00);
    $display("mode test done");
  endtask
  task t_irq;
    irq_pin(PIN_IRQ2, 1'b0, 2, 0);
    irq_pin(PIN_IRQ2, 1'b1, 2, 1);
    irq_pin(PIN_IRQ3, 1'b0, 3, 1);
    irq_pin(PIN_IRQ4, 1'b0, 4, 0);
    irq_pin(PIN_IRQ4, 1'b1, 4, 1);
    irq_pin(PIN_IRQ5, 1'b0, 5, 1);
    irq_pin(PIN_IRQ0, 1'b0, 0, 1);
    // Zero pin still low, so its level mode is exercised too
    lvl <= 2'b11;
    irq_pin(PIN_IRQ1, 1'b0, 1, 4);
    e1_v <= 8'hff;
    e3_v <= 8'hff;
    lvl <= 2'b00;
    cyc(4);
    $display("interrupt test done");
  endtask
  task t_alt_in;
    // Alternate inputs stay in quasi mode, never strong outputs
    spi_act <= 1'b1;
    tmr_mode <= 8'h02;
    e1_v <= 8'h6f;
    e3_v <= 8'hfe;
    e3_e[0] <= 1'b1;
    cyc(4);
    chk("slave sel", {7'h0, ss_n}, 8'h00);
    chk("sclk in", {7'h0, sck_in}, 8'h00);
    chk("rx", {7'h0, rxd}, 8'h00);
    chk("timers", {6'h0, t1c, t0c}, 8'h01);
    sfr(1'b0, ADDR_PORT1, 8'h00);
    chk("p1 read", rdata, 8'h6f);
    spi_act <= 1'b0;
    e1_v <= 8'hff;
    e3_v <= 8'hff;
    cyc(4);
    $display("alternate input test done");
  endtask
  task t_alt_out;
    txd <= 1'b0;
    cps <= 3'b101;
    sfr(1'b1, ADDR_ALT_SEL, 8'h02);
    chk("p3 out", pad3.out, 8'hbd);
    sfr(1'b0, ADDR_ALT_SEL, 8'h00);
    chk("alt sel", rdata, 8'h02);
    txd <= 1'b1;
    cps <= 3'b010;
    cyc(3);
    chk("p3 out", pad3.out, 8'hff);
    sfr(1'b1, ADDR_ALT_SEL, 8'h01);
    chk("sel one", pad3.out, 8'hbf);
    sfr(1'b1, ADDR_ALT_SEL, 8'h03);
    chk("sel three", pad3.out, 8'hbf);
    sfr(1'b1, ADDR_ALT_SEL, 8'h00);
    i2c_act <= 1'b1;
    sck_drv <= 1'b1;
    sck_out <= 1'b0;
    cyc(4);
    chk("sclk out", pad1.out, 8'h7f);
    chk("sclk back", {7'h0, sck_in}, 8'h00);
    i2c_act <= 1'b0;
    sck_drv <= 1'b0;
    sck_out <= 1'b1;
    cyc(4);
    $display("alternate output test done");
  endtask
  task t_reset_again;
    sfr(1'b1, ADDR_PORT1_DIRL, 8'haa);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(2);
    chk("p1 pad", pad1.pu & ~pad1.oe & pad1.out, 8'hff);
    chk("strap", {7'h0, strap}, 8'h00);
    $display("second reset test done");
  endtask
  // ****
  // Sequence and watchdog
  // ****
  initial begin
    t_reset;
    t_regs;
    t_modes;
    t_irq;
    t_alt_in;
    t_alt_out;
    t_reset_again;
    wrap_up;
  end
  initial begin
    cyc(20000);
    err_count++;
    wrap_up;
  end
endmodule
